// ---- design/ddr3_mpr_params.svh ----
// Constants for the calibration-pattern readout and DLL-off mode block
`ifndef DDR3_MPR_PARAMS_SVH
`define DDR3_MPR_PARAMS_SVH

// ==========================================================
// Mode register selection and field positions
`define MR_SEL_BURST 2'h0
`define MR_SEL_DLL 2'h1
`define MR_SEL_WLAT 2'h2
`define MR_SEL_PATTERN 2'h3
`define MR_RESET_VAL 16'h0000
`define BURST_BL_MSB 1
`define BURST_BL_LSB 0
`define BURST_CL_MSB 6
`define BURST_CL_LSB 4
`define DLLREG_OFF_BIT 0
`define DLLREG_AL_MSB 4
`define DLLREG_AL_LSB 3
`define WLAT_CWL_MSB 5
`define WLAT_CWL_LSB 3
`define PATREG_EN_BIT 2
`define PATREG_LOC_MSB 1
`define PATREG_LOC_LSB 0

// ==========================================================
// Field encodings
`define BL_FIXED8 2'h0
`define BL_OTF 2'h1
`define BL_FIXED4 2'h2
`define AL_ZERO 2'h0
`define AL_CL_M1 2'h1
`define AL_CL_M2 2'h2
`define CL_BASE 6'h04
`define CWL_BASE 6'h05
`define DLL_OFF_CL 6'h06
`define DLL_OFF_CWL 6'h06
`define DLL_OFF_SHIFT 6'h01

// ==========================================================
// Read addressing and pattern
`define ADDR_BC_BIT 12
`define ADDR_NIB_BIT 2
`define PAT_LOC_FIXED 2'h0
`define PAT_BYTE 8'hAA
`define PAT_RESERVED_DATA 8'h00
`define NIB_LOW 3'h0
`define NIB_HIGH 3'h4
`define BEAT_STEP 3'h2
`define CYC_BL8_LAST 2'h3
`define CYC_BC4_LAST 2'h1

`endif

// ---- design/ddr3_mpr_pkg.sv ----
// Types for the calibration-pattern readout and DLL-off mode block
package ddr3_mpr_pkg;

	typedef logic [15:0] mode_reg_t;
	typedef logic [5:0] lat_t;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_BURST = 2'b10
	} burst_state_e;

endpackage

// ---- design/ddr3_mpr_dll_off.sv ----
// DDR3 device side: mode registers, calibration-pattern reads, DLL-off latency
//
// Contract
// - Lane zero carries the pattern bit; other lanes repeat it or drive zero.
// - Eight-beat pattern reads return beats in order from beat zero, or from beat four (wrapping) when column bit 2 is high.
// - Chopped read: column bit 2 low gives beats 0-3, high gives 4-7.
// - Bank bits, column bits 9:3, auto-precharge and high bits are ignored.
// - Pattern reads honour fixed burst chop and on-the-fly chop via bit 12.
// - Pattern reads use the normal programmed read latency.
// - Beat zero maps to pattern LSB, beat seven to MSB.
// - Location 00 returns 0,1,0,1,... for full and chopped bursts.
// - A no-operation command starts nothing and disturbs nothing.
// - With chip select high no command is registered; bursts continue.
// - DLL control bit set to one disables the DLL until cleared.
// - DLL-off supports only read latency 6 and write latency 6.
// - DLL-off read data starts at additive plus read latency minus one.
// - Pattern-mode bit set enables pattern mode; reads go to chosen location.
// - In pattern mode read with auto-precharge acts as plain read.
`include "ddr3_mpr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ddr3_mpr_dll_off
	import ddr3_mpr_pkg::*;
#(
	parameter int DQ_WIDTH = 8,
	parameter int LAT_DEPTH = 32,
	parameter bit REPLICATE_LANES = 1'b1
)
(
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic linkClk,
	// Command and address pins, sampled on linkClk
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [2:0] ba,
	input wire logic [15:0] addr,
	// Read data pins, one beat per clock edge
	output logic [DQ_WIDTH-1:0] dqRise,
	output logic [DQ_WIDTH-1:0] dqFall,
	output logic dqOe,
	output logic dqsOe,
	// Status on sys_clk
	output logic dllOffStat,
	output logic patModeStat,
	output logic dllOffLatOk,
	output logic patBurstPulse
);

	localparam int IDX_W = $clog2(LAT_DEPTH);
	// DLL-off read latency with no additive latency, in link clocks
	localparam int DLL_OFF_RL = `DLL_OFF_CL - `DLL_OFF_SHIFT;

	// ==========================================================
	// Helpers
	function automatic lat_t fieldPlus(input logic [2:0] field, input lat_t base);
		fieldPlus = lat_t'({3'h0, field}) + base;
	endfunction

	function automatic logic [DQ_WIDTH-1:0] laneFill(input logic b);
		laneFill = REPLICATE_LANES ? {DQ_WIDTH{b}} : {{(DQ_WIDTH-1){1'b0}}, b};
	endfunction

	// ==========================================================
	// Command decode
	mode_reg_t mr_q [4];
	wire logic cmdSel = !csN;
	wire logic mrsCmd = cmdSel && !rasN && !casN && !weN;
	wire logic readCmd = cmdSel && rasN && !casN && weN;
	wire logic nopCmd = cmdSel && rasN && casN && weN;
	wire logic mrsHit = mrsCmd && !ba[2];
	wire logic dllOff = mr_q[`MR_SEL_DLL][`DLLREG_OFF_BIT];
	wire logic patOn = mr_q[`MR_SEL_PATTERN][`PATREG_EN_BIT];
	wire logic [1:0] patLoc = mr_q[`MR_SEL_PATTERN][`PATREG_LOC_MSB:`PATREG_LOC_LSB];
	wire logic [1:0] blMode = mr_q[`MR_SEL_BURST][`BURST_BL_MSB:`BURST_BL_LSB];
	wire logic [1:0] alMode = mr_q[`MR_SEL_DLL][`DLLREG_AL_MSB:`DLLREG_AL_LSB];

	// Only the command, the chop bit and column bit 2 matter here;
	// auto-precharge in pattern mode is dropped, no precharge happens
	wire logic readPat = readCmd && patOn;
	wire logic readBc4 = (blMode == `BL_FIXED4) ||
		((blMode == `BL_OTF) && !addr[`ADDR_BC_BIT]);
	wire logic readNibHi = addr[`ADDR_NIB_BIT];

	// ==========================================================
	// Latency
	wire lat_t casLat = fieldPlus(mr_q[`MR_SEL_BURST][`BURST_CL_MSB:`BURST_CL_LSB], `CL_BASE);
	wire lat_t casWrLat = fieldPlus(mr_q[`MR_SEL_WLAT][`WLAT_CWL_MSB:`WLAT_CWL_LSB], `CWL_BASE);
	lat_t addLat;
	always_comb
	begin
		case (alMode)
			`AL_CL_M1: addLat = casLat - 6'h01;
			`AL_CL_M2: addLat = casLat - 6'h02;
			default: addLat = 6'h00;
		endcase
	end
	wire lat_t alCl = addLat + casLat;
	// DLL-off moves the data window one clock earlier
	wire lat_t rdLat = dllOff ? alCl - `DLL_OFF_SHIFT : alCl;
	wire lat_t tapLat = rdLat - 6'h01;
	wire logic [IDX_W-1:0] tapIdx = tapLat[IDX_W-1:0];
	wire logic latOk = (casLat == `DLL_OFF_CL) && (casWrLat == `DLL_OFF_CWL);

	// ==========================================================
	// Mode registers: only MRS writes them, NOP and deselect leave them
	always_ff @(posedge linkClk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < 4; i++)
			begin
				mr_q[i] <= `MR_RESET_VAL;
			end
		end
		else if (mrsHit)
		begin
			mr_q[ba[1:0]] <= addr;
		end
	end

	// ==========================================================
	// Latency pipe: every read slot shifts one clock; several may be in flight
	logic [LAT_DEPTH-1:0] pipeValid_q;
	logic [LAT_DEPTH-1:0] pipeBc4_q;
	logic [LAT_DEPTH-1:0] pipeNib_q;

	always_ff @(posedge linkClk or posedge rst)
	begin
		if (rst)
		begin
			pipeValid_q <= '0;
			pipeBc4_q <= '0;
			pipeNib_q <= '0;
		end
		else
		begin
			pipeValid_q <= {pipeValid_q[LAT_DEPTH-2:0], readPat};
			pipeBc4_q <= {pipeBc4_q[LAT_DEPTH-2:0], readBc4};
			pipeNib_q <= {pipeNib_q[LAT_DEPTH-2:0], readNibHi};
		end
	end

	wire logic startBurst = pipeValid_q[tapIdx];
	wire logic tapBc4 = pipeBc4_q[tapIdx];
	wire logic tapNib = pipeNib_q[tapIdx];

	// ==========================================================
	// Burst generator
	burst_state_e state_q, state_d;
	logic [1:0] cycLeft_q, cycLeft_d;
	logic [2:0] beatPos_q, beatPos_d;
	logic [DQ_WIDTH-1:0] dqRise_d, dqFall_d;
	logic dqOe_d;
	logic burstToggle_q;

	// Reserved locations return zeros rather than arbitrary data
	wire logic [7:0] patByte = (patLoc == `PAT_LOC_FIXED) ? `PAT_BYTE : `PAT_RESERVED_DATA;
	wire logic [2:0] firstPos = tapNib ? `NIB_HIGH : `NIB_LOW;
	wire logic [2:0] curPos = startBurst ? firstPos : beatPos_q;
	wire logic [2:0] nextPos = curPos + 3'h1;
	wire logic beatsLeft = (state_q == ST_BURST) && (cycLeft_q != 2'h0);

	always_comb
	begin
		state_d = ST_IDLE;
		cycLeft_d = 2'h0;
		beatPos_d = beatPos_q;
		dqOe_d = 1'b0;
		dqRise_d = '0;
		dqFall_d = '0;
		if (startBurst || beatsLeft)
		begin
			state_d = ST_BURST;
			dqOe_d = 1'b1;
			// Beat n takes pattern bit n, lowest beat on the rising edge
			dqRise_d = laneFill(patByte[curPos]);
			dqFall_d = laneFill(patByte[nextPos]);
			beatPos_d = curPos + `BEAT_STEP;
			if (startBurst)
			begin
				cycLeft_d = tapBc4 ? `CYC_BC4_LAST : `CYC_BL8_LAST;
			end
			else
			begin
				cycLeft_d = cycLeft_q - 2'h1;
			end
		end
	end

	always_ff @(posedge linkClk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			cycLeft_q <= 2'h0;
			beatPos_q <= 3'h0;
			dqOe <= 1'b0;
			dqRise <= '0;
			dqFall <= '0;
			burstToggle_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cycLeft_q <= cycLeft_d;
			beatPos_q <= beatPos_d;
			dqOe <= dqOe_d;
			dqRise <= dqRise_d;
			dqFall <= dqFall_d;
			burstToggle_q <= burstToggle_q ^ startBurst;
		end
	end

	// Strobe is driven exactly while data is
	assign dqsOe = dqOe;

	// ==========================================================
	// The latency check is combinational; it is registered on linkClk first
	// so that no glitch can reach the synchroniser
	logic latOkFlag_q;

	always_ff @(posedge linkClk or posedge rst)
	begin
		if (rst)
		begin
			latOkFlag_q <= 1'b0;
		end
		else
		begin
			latOkFlag_q <= latOk && dllOff;
		end
	end

	// Status crossing into sys_clk: levels by two flops, bursts by toggle
	wire logic [3:0] linkStat = {burstToggle_q, latOkFlag_q, patOn, dllOff};
	logic [3:0] statMeta_q;
	logic [3:0] statSync_q;
	logic togglePrev_q;
	logic burstPulse_q;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			statMeta_q <= 4'h0;
			statSync_q <= 4'h0;
			togglePrev_q <= 1'b0;
			burstPulse_q <= 1'b0;
		end
		else
		begin
			statMeta_q <= linkStat;
			statSync_q <= statMeta_q;
			togglePrev_q <= statSync_q[3];
			burstPulse_q <= statSync_q[3] ^ togglePrev_q;
		end
	end

	assign dllOffStat = statSync_q[0];
	assign patModeStat = statSync_q[1];
	assign dllOffLatOk = statSync_q[2];
	assign patBurstPulse = burstPulse_q;

	// ==========================================================
	// Checks on the link domain
	default clocking cbLink @(posedge linkClk);
	endclocking
	default disable iff (rst);

	AST_LANES: assert property (
		dqOe |-> (dqRise == laneFill(dqRise[0])) && (dqFall == laneFill(dqFall[0])))
		else $error("Pattern lanes do not follow lane zero");

	AST_PATTERN: assert property (
		(dqOe && patLoc == `PAT_LOC_FIXED) |-> (!dqRise[0] && dqFall[0]))
		else $error("Pattern location 00 did not return alternating beats");

	AST_BL8_LEN: assert property (
		(startBurst && !tapBc4) |-> ##1 dqOe [*4])
		else $error("Eight-beat pattern burst was not four clocks long");

	AST_BC4_LEN: assert property (
		(startBurst && tapBc4 && !tapNib) |-> ##1 (dqOe && beatPos_q == 3'h2) ##1 dqOe)
		else $error("Chopped low-nibble burst length or order wrong");

	AST_DESELECT: assert property (
		(csN || nopCmd) |=> (!pipeValid_q[0] && $stable(mr_q[`MR_SEL_DLL])
			&& $stable(mr_q[`MR_SEL_PATTERN])))
		else $error("Deselect or no-operation disturbed state");

	AST_DLL_BIT: assert property (
		(mrsHit && ba[1:0] == `MR_SEL_DLL) |=> (dllOff == $past(addr[`DLLREG_OFF_BIT])))
		else $error("DLL control bit not taken from mode write");

	// Checked against the burst start, not against the latency sum itself
	AST_DLLOFF_LAT: assert property (
		(readPat && dllOff && casLat == `DLL_OFF_CL && alMode == `AL_ZERO)
			|-> ##DLL_OFF_RL startBurst)
		else $error("DLL-off pattern read did not start one clock early");

	AST_PAT_ENABLE: assert property (
		(mrsHit && ba[1:0] == `MR_SEL_PATTERN) |=> (patOn == $past(addr[`PATREG_EN_BIT])))
		else $error("Pattern mode bit not taken from mode write");

endmodule // ddr3_mpr_dll_off

`default_nettype wire

// ---- tb/ddr3_ctrl_model.sv ----
// Controller model that drives the command pins of the pattern and DLL-off block
`timescale 1ns/1ps
`default_nettype none

module ddr3_ctrl_model
(
	// Link clock
	input wire logic linkClk,
	// Command and address pins
	output logic csN,
	output logic rasN,
	output logic casN,
	output logic weN,
	output logic [2:0] ba,
	output logic [15:0] addr
);
	initial
	begin
		csN = 1'b1;
		rasN = 1'b1;
		casN = 1'b1;
		weN = 1'b1;
		ba = 3'h5;
		addr = 16'hA5C3;
	end

	// ==========================================================
	// Idle cycles
	// Even n gives a no-operation, odd n a deselect; unused pins flip every cycle
	// so that a stale value never looks like a clean command
	task automatic step(input int n);
		@(posedge linkClk);
		csN <= n[0];
		rasN <= n[0] ? ~rasN : 1'b1;
		casN <= n[0] ? ~casN : 1'b1;
		weN <= n[0] ? ~weN : 1'b1;
		ba <= ~ba;
		addr <= ~addr;
	endtask

	// ==========================================================
	// Commands: one selected cycle, then a deselect
	task automatic cmd(input logic r, input logic c, input logic w, input logic [2:0] b,
		input logic [15:0] a);
		@(posedge linkClk);
		csN <= 1'b0;
		rasN <= r;
		casN <= c;
		weN <= w;
		ba <= b;
		addr <= a;
		step(1);
	endtask

	// Mode register writes may come at any time outside bursts
	task automatic mrs(input logic [2:0] b, input logic [15:0] v);
		cmd(1'b0, 1'b0, 1'b0, b, v);
	endtask

	// Bank bits are junk on purpose; low column bits are given by the caller
	task automatic rd(input logic [15:0] a);
		cmd(1'b1, 1'b0, 1'b1, 3'h6, a);
	endtask
endmodule // ddr3_ctrl_model

`default_nettype wire

// ---- tb/tb_ddr3_mpr_dll_off.sv ----
// Self-checking bench for the calibration-pattern readout and DLL-off block
`timescale 1ns/1ps
`default_nettype none

module tb_ddr3_mpr_dll_off;
	import ddr3_mpr_pkg::*;
	logic sys_clk = 1'b0;
	logic linkClk = 1'b0;
	logic rst = 1'b1;
	logic csN, rasN, casN, weN, dqOe, dqsOe, dllOffStat, patModeStat, dllOffLatOk, patBurstPulse;
	logic [2:0] ba;
	logic [15:0] addr;
	logic [7:0] dqRise, dqFall;
	logic [7:0] pat = 8'hAA;
	int n_errors = 0;
	int checks = 0;
	int pulses = 0;
	int bursts = 0;

	// ==========================================================
	// Clocks, parts and monitors
	always #4 sys_clk = ~sys_clk;
	// Link clock stays at one slow rate, well inside any refresh interval
	always #62.5 linkClk = ~linkClk;
	always @(posedge sys_clk) if (patBurstPulse === 1'b1) pulses++;

	ddr3_ctrl_model ddr3_ctrl_model_i (.linkClk(linkClk), .csN(csN), .rasN(rasN), .casN(casN),
		.weN(weN), .ba(ba), .addr(addr));
	ddr3_mpr_dll_off ddr3_mpr_dll_off_i (.sys_clk(sys_clk), .rst(rst), .linkClk(linkClk),
		.csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .ba(ba), .addr(addr), .dqRise(dqRise),
		.dqFall(dqFall), .dqOe(dqOe), .dqsOe(dqsOe), .dllOffStat(dllOffStat),
		.patModeStat(patModeStat), .dllOffLatOk(dllOffLatOk), .patBurstPulse(patBurstPulse));

	// ==========================================================
	// Compare and access tasks
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_n(input string what, input int exp, input int got);
		checks++;
		if (got != exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic settle;
		for (int k = 0; k < 4; k++) ddr3_ctrl_model_i.step(k);
	endtask

	// Read, then follow the burst while the pins carry no-ops and deselects;
	// lat counts from the read edge, base is the first beat, lanes copy lane zero
	task automatic rd(input logic [15:0] a, input int lat, input int ncyc, input int base,
		input logic [7:0] p);
		int seen;
		int first;
		int b;
		seen = 0;
		first = -1;
		ddr3_ctrl_model_i.rd(a);
		for (int k = 0; k < 40; k++)
		begin
			ddr3_ctrl_model_i.step(k);
			@(negedge linkClk);
			chk("dqsOe", {15'h0000, dqOe}, {15'h0000, dqsOe});
			if (dqOe === 1'b1)
			begin
				if (first < 0) first = k + 1;
				b = (base + 2 * seen) % 8;
				chk("dqRise", {8'h00, {8{p[b]}}}, {8'h00, dqRise});
				chk("dqFall", {8'h00, {8{p[b + 1]}}}, {8'h00, dqFall});
				seen++;
			end
		end
		chk_n("dataCycles", ncyc, seen);
		if (ncyc > 0) chk_n("latency", lat, first);
		if (ncyc > 0) bursts++;
		chk_n("burstPulses", bursts, pulses);
		$display("Read %h finished", a);
	endtask

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// Watchdog: the sequence needs about 70 us of link time
	initial
	begin
		#400000;
		n_errors++;
		$display("Watchdog expired");
		complete_run;
	end

	// ==========================================================
	// Test sequence
	initial
	begin
		// Reset spans 12 link cycles, which also covers both clock domains
		repeat (12) @(posedge linkClk);
		rst <= 1'b0;
		chk("dqOe", 16'h0000, {15'h0000, dqOe});
		ddr3_ctrl_model_i.mrs(3'h3, 16'h0004);
		ddr3_ctrl_model_i.mrs(3'h7, 16'h0000);
		// Idle time stands for the lock wait before the first pattern read
		settle;
		chk("patModeStat", 16'h0001, {15'h0000, patModeStat});
		rd(16'h07F8, 4, 4, 0, pat);
		ddr3_ctrl_model_i.mrs(3'h0, 16'h0002);
		rd(16'h0000, 4, 2, 0, pat);
		rd(16'h0004, 4, 2, 4, pat);
		ddr3_ctrl_model_i.mrs(3'h0, 16'h0001);
		rd(16'h1000, 4, 4, 0, pat);
		rd(16'h0004, 4, 2, 4, pat);
		// Chop code 11 behaves as a full burst
		ddr3_ctrl_model_i.mrs(3'h0, 16'h0003);
		rd(16'h0000, 4, 4, 0, pat);
		ddr3_ctrl_model_i.mrs(3'h0, 16'h0020);
		ddr3_ctrl_model_i.mrs(3'h1, 16'h0008);
		rd(16'h0000, 11, 4, 0, pat);
		ddr3_ctrl_model_i.mrs(3'h1, 16'h0010);
		rd(16'h0000, 10, 4, 0, pat);
		ddr3_ctrl_model_i.mrs(3'h1, 16'h0001);
		// Idle cycles stand for update delay, self refresh and its exit
		settle;
		ddr3_ctrl_model_i.mrs(3'h2, 16'h0008);
		settle;
		chk("dllOffStat", 16'h0001, {15'h0000, dllOffStat});
		chk("dllOffLatOk", 16'h0001, {15'h0000, dllOffLatOk});
		rd(16'h0000, 5, 4, 0, pat);
		ddr3_ctrl_model_i.mrs(3'h1, 16'h0000);
		settle;
		chk("dllOffStat", 16'h0000, {15'h0000, dllOffStat});
		chk("dllOffLatOk", 16'h0000, {15'h0000, dllOffLatOk});
		rd(16'h0000, 6, 4, 0, pat);
		ddr3_ctrl_model_i.mrs(3'h3, 16'h0005);
		rd(16'h0000, 6, 4, 0, 8'h00);
		ddr3_ctrl_model_i.mrs(3'h3, 16'h0000);
		settle;
		chk("patModeStat", 16'h0000, {15'h0000, patModeStat});
		rd(16'h0000, 6, 0, 0, pat);
		complete_run;
	end
endmodule // tb_ddr3_mpr_dll_off

`default_nettype wire
